// ==== hdl/daau_top.sv ====
// two independent aux logic/arith units behind an apb register slave
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "daau_params.svh"

// one auxiliary function unit with its own input and control registers
module daau_unit
    import daau_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_wr_in1,
    input wire logic i_wr_in2,
    input wire logic i_wr_ctrl,
    input daau_pkg::daau_val_t i_wval,
    input wire logic i_wsw,
    input wire logic [2:0] i_wmode,
    output daau_pkg::daau_val_t o_in1,
    output daau_pkg::daau_val_t o_in2,
    output logic o_sw,
    output logic [2:0] o_mode,
    output daau_pkg::daau_val_t o_out
);
    daau_val_t in1;
    daau_val_t in2;
    logic sw;
    logic [2:0] mode;
    daau_val_t out;
    daau_val_t next_out;
    daau_val_t result;

    // input registers, already clamped to range by the bus side
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            in1 <= `DAAU_RST_VAL; // RL13
            in2 <= `DAAU_RST_VAL; // RL13
        end
        else
        begin
            if (i_wr_in1)
            begin
                in1 <= i_wval; // RL2
            end
            if (i_wr_in2)
            begin
                in2 <= i_wval; // RL2
            end
        end
    end

    // switch and operation select
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sw <= 1'b0; // RL13
            mode <= `DAAU_RST_MODE;
        end
        else if (i_wr_ctrl)
        begin
            sw <= i_wsw; // RL5
            mode <= i_wmode; // RL3
        end
    end

    // selected function; nonzero counts as true
    always_comb
    begin
        result = in1;
        case (daau_mode_t'(mode)) // RL3
            DAAU_MODE_PASS: result = in2; // RL6
            DAAU_MODE_INV: result = (in1 == 0) ? `DAAU_TRUE_VAL : `DAAU_FALSE_VAL; // RL7 RL14
            DAAU_MODE_AND: result = ((in1 != 0) && (in2 != 0)) ?
                `DAAU_TRUE_VAL : `DAAU_FALSE_VAL; // RL8 RL14
            DAAU_MODE_OR: result = ((in1 != 0) || (in2 != 0)) ?
                `DAAU_TRUE_VAL : `DAAU_FALSE_VAL; // RL9 RL14
            DAAU_MODE_NEG: result = -in1; // RL10
            DAAU_MODE_ABS: result = (in1 < 0) ? -in1 : in1; // RL11
            DAAU_MODE_CMP: result = (in1 > in2) ? `DAAU_TRUE_VAL : `DAAU_FALSE_VAL; // RL12
            default: result = in1; // RL15
        endcase
    end

    // switch off passes input 1 whatever the code
    always_comb
    begin
        next_out = sw ? result : in1; // RL4 RL5
    end

    // output refreshed every cycle so switch changes show on the next edge
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            out <= `DAAU_RST_VAL; // RL13
        end
        else
        begin
            out <= next_out; // RL15
        end
    end

    assign o_in1 = in1;
    assign o_in2 = in2;
    assign o_sw = sw;
    assign o_mode = mode;
    assign o_out = out;

    // switch turned on one cycle ago
    sequence s_switch_on;
        !sw ##1 sw;
    endsequence

    // pass code held while switched on
    sequence s_pass_on;
        sw && (mode == DAAU_MODE_PASS);
    endsequence

    AST_OFF_FOLLOWS_IN1: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL4
        !sw |=> (out == $past(in1)))
        else $error("output differs from input 1 with switch off");

    AST_SWITCH_DYNAMIC: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL5
        (s_switch_on ##0 (mode == DAAU_MODE_NEG)) |=> (out == -$past(in1)))
        else $error("switch on did not move output to function result");

    AST_PASS_IN2: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL6
        s_pass_on |=> (out == $past(in2)))
        else $error("pass code did not give input 2");

    AST_INVERT: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL7
        (sw && (mode == DAAU_MODE_INV)) |=>
        (out == (($past(in1) == 0) ? `DAAU_TRUE_VAL : `DAAU_FALSE_VAL)))
        else $error("inversion result wrong");

    AST_AND: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL8
        (sw && (mode == DAAU_MODE_AND) && (in1 != 0) && (in2 == 0)) |=> (out == 0))
        else $error("and of true and false not false");

    AST_OR: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL9
        (sw && (mode == DAAU_MODE_OR) && (in1 == 0) && (in2 != 0)) |=>
        (out == `DAAU_TRUE_VAL))
        else $error("or of false and true not true");

    AST_NEGATE: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL10
        (sw && (mode == DAAU_MODE_NEG)) |=> (out + $past(in1) == 0))
        else $error("negation does not cancel input 1");

    AST_MAGNITUDE: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL11
        (sw && (mode == DAAU_MODE_ABS)) |=>
        ((out >= 0) && ((out == $past(in1)) || (out == -$past(in1)))))
        else $error("magnitude wrong");

    AST_COMPARE_EQUAL: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL12
        (sw && (mode == DAAU_MODE_CMP) && (in1 == in2)) |=> (out == 0))
        else $error("equal inputs compared as greater");

    AST_COMPARE_GT: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL12
        (sw && (mode == DAAU_MODE_CMP) && (in1 > in2)) |=> (out == `DAAU_TRUE_VAL))
        else $error("greater input not reported");

    AST_BOOL_LEVELS: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL14
        (sw && ((mode == DAAU_MODE_INV) || (mode == DAAU_MODE_OR))) |=>
        ((out == `DAAU_TRUE_VAL) || (out == `DAAU_FALSE_VAL)))
        else $error("boolean result not 0 or 1");

    AST_CODE_SEVEN: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL15
        (sw && (mode == DAAU_MODE_RSVD)) |=> (out == $past(in1)))
        else $error("unused code did not pass input 1");

    AST_RANGE: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL2
        (in1 >= `DAAU_VAL_MIN) && (in1 <= `DAAU_VAL_MAX) &&
        (in2 >= `DAAU_VAL_MIN) && (in2 <= `DAAU_VAL_MAX))
        else $error("input outside percentage range");

    AST_RESET_STATE: assert property (@(posedge i_clk) // RL13
        !i_rst_n |-> ((out == 0) && (in1 == 0) && (in2 == 0) && !sw))
        else $error("unit not cleared during reset");
endmodule

// Function
// RL1: two independent units, own inputs and controls
// RL2: inputs signed hundredths, -32768.00 to 32768.00
// RL3: select code picks function zero to six
// RL4: switch off: output equals input one
// RL5: switch toggles output at run time
// RL6: code zero on: output is input two
// RL7: code one on: boolean complement of input one
// RL8: code two on: boolean and of inputs
// RL9: code three on: boolean or of inputs
// RL10: code four on: negate input one
// RL11: code five on: absolute value of input one
// RL12: code six on: one if input1 greater
// RL13: reset: switch off, inputs and output zero
// RL14: nonzero is true; results one or zero
// RL15: recompute each cycle; codes seven up pass
module daau_top
    import daau_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output daau_pkg::daau_val_t o_unit0_out,
    output daau_pkg::daau_val_t o_unit1_out
);
    logic rst_meta_n;
    logic rst_n;
    logic addr_ok;
    logic unit_sel;
    logic [1:0] reg_sel;
    logic wr_access;
    logic next_slverr;
    logic [31:0] next_rdata;
    logic [31:0] prdata;
    logic pslverr;
    daau_val_t wval;
    logic [`DAAU_NUM_UNITS-1:0] wr_in1;
    logic [`DAAU_NUM_UNITS-1:0] wr_in2;
    logic [`DAAU_NUM_UNITS-1:0] wr_ctrl;
    daau_val_t u_in1 [`DAAU_NUM_UNITS];
    daau_val_t u_in2 [`DAAU_NUM_UNITS];
    daau_val_t u_out [`DAAU_NUM_UNITS];
    logic u_sw [`DAAU_NUM_UNITS];
    logic [2:0] u_mode [`DAAU_NUM_UNITS];

    // reset released through two flops, asserted at once
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // address decode: two blocks of four aligned words
    assign addr_ok = (i_paddr[7:5] == 3'h0) && (i_paddr[1:0] == 2'h0);
    assign unit_sel = i_paddr[4];
    assign reg_sel = i_paddr[3:2];
    assign wr_access = i_psel && i_penable && i_pwrite && addr_ok && !pslverr;

    // writes beyond the percentage range are clamped, not wrapped
    always_comb
    begin
        if ($signed(i_pwdata) > 32'(`DAAU_VAL_MAX))
        begin
            wval = `DAAU_VAL_MAX; // RL2
        end
        else if ($signed(i_pwdata) < 32'(`DAAU_VAL_MIN))
        begin
            wval = `DAAU_VAL_MIN; // RL2
        end
        else
        begin
            wval = i_pwdata[23:0];
        end
    end

    // per-unit write strobes, taken at the access phase
    always_comb
    begin
        wr_in1 = '0;
        wr_in2 = '0;
        wr_ctrl = '0;
        if (wr_access)
        begin
            wr_in1[unit_sel] = (reg_sel == `DAAU_REG_IN1);
            wr_in2[unit_sel] = (reg_sel == `DAAU_REG_IN2);
            wr_ctrl[unit_sel] = (reg_sel == `DAAU_REG_CTRL);
        end
    end

    // two identical units, nothing shared but the bus
    genvar u;
    generate
        for (u = 0; u < `DAAU_NUM_UNITS; u++)
        begin : g_unit
            daau_unit u_daau_unit ( // RL1
                .i_clk(i_clk),
                .i_rst_n(rst_n),
                .i_wr_in1(wr_in1[u]),
                .i_wr_in2(wr_in2[u]),
                .i_wr_ctrl(wr_ctrl[u]),
                .i_wval(wval),
                .i_wsw(i_pwdata[`DAAU_CTRL_SW_BIT]),
                .i_wmode(i_pwdata[`DAAU_CTRL_MODE_MSB:`DAAU_CTRL_MODE_LSB]),
                .o_in1(u_in1[u]),
                .o_in2(u_in2[u]),
                .o_sw(u_sw[u]),
                .o_mode(u_mode[u]),
                .o_out(u_out[u])
            );
        end
    endgenerate

    // read mux and error flag, values sign-extended to the word
    always_comb
    begin
        next_rdata = 32'h00000000;
        next_slverr = !addr_ok || (i_pwrite && (reg_sel == `DAAU_REG_OUT));
        case (reg_sel)
            `DAAU_REG_IN1: next_rdata = 32'(u_in1[unit_sel]);
            `DAAU_REG_IN2: next_rdata = 32'(u_in2[unit_sel]);
            `DAAU_REG_CTRL: next_rdata = {28'h0000000, u_mode[unit_sel], u_sw[unit_sel]};
            `DAAU_REG_OUT: next_rdata = 32'(u_out[unit_sel]);
            default: next_rdata = 32'h00000000;
        endcase
        if (!addr_ok || i_pwrite)
        begin
            next_rdata = 32'h00000000;
        end
    end

    // answer captured in the setup cycle so data comes from flops
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else if (i_psel && !i_penable)
        begin
            prdata <= next_rdata;
            pslverr <= next_slverr;
        end
    end

    // zero wait states; error only shown in the access phase
    assign o_pready = 1'b1;
    assign o_prdata = prdata;
    assign o_pslverr = pslverr && i_psel && i_penable;
    assign o_unit0_out = u_out[0];
    assign o_unit1_out = u_out[1];

    AST_UNITS_APART: assert property (@(posedge i_clk) disable iff (!rst_n) // RL1
        wr_access && (unit_sel == 1'b0) |=> (u_in1[1] == $past(u_in1[1])) &&
        (u_in2[1] == $past(u_in2[1])) && (u_sw[1] == $past(u_sw[1])))
        else $error("write to unit 0 disturbed unit 1");

    AST_READ_OUT: assert property (@(posedge i_clk) disable iff (!rst_n) // RL15
        (i_psel && !i_penable && !i_pwrite && addr_ok && (reg_sel == `DAAU_REG_OUT))
        |=> (o_prdata == 32'($past(u_out[unit_sel]))))
        else $error("read of output register wrong");
endmodule

// ==== pkg/daau_params.svh ====
// register map, field positions, reset values and value limits of the aux logic/arith unit
`ifndef DAAU_PARAMS_SVH
`define DAAU_PARAMS_SVH

// apb address and data widths
`define DAAU_ADDR_W 8
`define DAAU_DATA_W 32
// signed hundredths of a percent: -32768.00 .. +32768.00 needs 23 bits, 24 kept
`define DAAU_VAL_W 24

// per-unit register offsets, unit n sits at n * stride
`define DAAU_UNIT_STRIDE 8'h10
`define DAAU_REG_IN1 2'h0
`define DAAU_REG_IN2 2'h1
`define DAAU_REG_CTRL 2'h2
`define DAAU_REG_OUT 2'h3
`define DAAU_NUM_UNITS 2

// control register fields
`define DAAU_CTRL_SW_BIT 0
`define DAAU_CTRL_MODE_LSB 1
`define DAAU_CTRL_MODE_MSB 3

// value limits in hundredths: +/-3276800
`define DAAU_VAL_MAX 24'sh320000
`define DAAU_VAL_MIN 24'shce0000
// boolean true is 1.00 %
`define DAAU_TRUE_VAL 24'sh000064
`define DAAU_FALSE_VAL 24'sh000000

// reset values
`define DAAU_RST_VAL 24'sh000000
`define DAAU_RST_MODE 3'h0

`endif

// ==== pkg/daau_pkg.sv ====
// types shared by the aux logic/arith unit
package daau_pkg;
    typedef logic signed [23:0] daau_val_t;
    typedef enum logic [2:0] {
        DAAU_MODE_PASS = 3'h0,
        DAAU_MODE_INV = 3'h1,
        DAAU_MODE_AND = 3'h2,
        DAAU_MODE_OR = 3'h3,
        DAAU_MODE_NEG = 3'h4,
        DAAU_MODE_ABS = 3'h5,
        DAAU_MODE_CMP = 3'h6,
        DAAU_MODE_RSVD = 3'h7
    } daau_mode_t;
endpackage

// ==== testbench/tb_top.sv ====
// self-checking bench for the dual aux logic/arith unit
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("CHECK FAILED t=%0t got %h exp %h", $time, (got), (exp)); \
        end \
    end

module tb_top;
    import daau_pkg::*;
    localparam daau_val_t TRUE_V = 24'sh000064;
    logic i_clk;
    logic i_rst_n;
    logic i_psel;
    logic i_penable;
    logic i_pwrite;
    logic [7:0] i_paddr;
    logic [31:0] i_pwdata;
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    daau_val_t o_unit0_out;
    daau_val_t o_unit1_out;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [31:0] rdat;
    logic rerr;
    daau_val_t pin;
    logic [31:0] rv;

    daau_top u_daau_top (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_psel(i_psel),
        .i_penable(i_penable),
        .i_pwrite(i_pwrite),
        .i_paddr(i_paddr),
        .i_pwdata(i_pwdata),
        .o_prdata(o_prdata),
        .o_pready(o_pready),
        .o_pslverr(o_pslverr),
        .o_unit0_out(o_unit0_out),
        .o_unit1_out(o_unit1_out)
    );

    // 50 MHz clock
    initial
    begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    // verdict and end of run
    task automatic summarize();
        if (error_cnt == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // hang guard, well above the ~1500 cycles the run needs
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            summarize();
        end
    end

    // one apb transfer; an idle cycle always precedes the setup cycle
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        @(posedge i_clk);
        while (o_pready !== 1'b1)
            @(posedge i_clk);
        rdat = o_prdata;
        rerr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic ctrl(input int u, input logic [2:0] m, input logic sw);
        apb(1'b1, 8'(u * 16 + 8), {28'h0000000, m, sw});
    endtask

    task automatic setup(input int u, input daau_val_t a, input daau_val_t b,
        input logic [2:0] m, input logic sw);
        apb(1'b1, 8'(u * 16), {{8{a[23]}}, a});
        apb(1'b1, 8'(u * 16 + 4), {{8{b[23]}}, b});
        ctrl(u, m, sw);
    endtask

    // output lags its registers by one edge, so sample mid-cycle after it
    task automatic obs(input int u);
        @(posedge i_clk);
        @(negedge i_clk);
        pin = (u == 0) ? o_unit0_out : o_unit1_out;
        apb(1'b0, 8'(u * 16 + 12), 32'h00000000);
        rv = rdat;
    endtask

    function automatic daau_val_t f_exp(logic [2:0] m, daau_val_t a, daau_val_t b);
        case (m)
            3'h0: return b;
            3'h1: return (a == 0) ? TRUE_V : 24'sh000000;
            3'h2: return (a != 0 && b != 0) ? TRUE_V : 24'sh000000;
            3'h3: return (a != 0 || b != 0) ? TRUE_V : 24'sh000000;
            3'h4: return -a;
            3'h5: return (a < 0) ? -a : a;
            3'h6: return (a > b) ? TRUE_V : 24'sh000000;
            default: return a;
        endcase
    endfunction

    task automatic t_reset_vals();
        for (int u = 0; u < 2; u++)
        begin
            for (int r = 0; r < 4; r++)
            begin
                apb(1'b0, 8'(u * 16 + r * 4), 32'h00000000);
                `CHK(rdat, 32'h00000000)
            end
        end
        // outputs are relaunched on every edge, so look between edges
        @(negedge i_clk);
        `CHK({o_unit0_out, o_unit1_out}, 48'h000000000000)
    endtask

    // every code, switch on then off, on both units
    task automatic t_modes();
        daau_val_t av[4] = '{24'sh0001f4, 24'sh000000, 24'sh0000fa, 24'shfffc18};
        daau_val_t bv[4] = '{24'shfffed4, 24'sh0002bc, 24'sh0000fa, 24'sh000000};
        daau_val_t e;
        for (int u = 0; u < 2; u++)
        begin
            for (int m = 0; m < 8; m++)
            begin
                for (int p = 0; p < 4; p++)
                begin
                    setup(u, av[p], bv[p], 3'(m), 1'b1);
                    e = f_exp(3'(m), av[p], bv[p]);
                    obs(u);
                    `CHK(pin, e)
                    `CHK(rv, {{8{e[23]}}, e})
                    ctrl(u, 3'(m), 1'b0);
                    obs(u);
                    `CHK(pin, av[p])
                end
            end
        end
    endtask

    task automatic t_toggle();
        setup(0, 24'sh0004d2, 24'shffffb3, 3'h4, 1'b1);
        obs(0);
        `CHK(pin, 24'shfffb2e)
        ctrl(0, 3'h4, 1'b0);
        obs(0);
        `CHK(pin, 24'sh0004d2)
        ctrl(0, 3'h4, 1'b1);
        obs(0);
        `CHK(pin, 24'shfffb2e)
    endtask

    task automatic t_indep();
        setup(0, 24'sh000011, 24'sh000222, 3'h0, 1'b1);
        setup(1, 24'shfffc7c, 24'sh000333, 3'h5, 1'b1);
        obs(1);
        `CHK(pin, 24'sh000384)
        @(negedge i_clk);
        `CHK(o_unit0_out, 24'sh000222)
    endtask

    // write clamp at both ends, and the lower extreme through negate and magnitude
    task automatic t_limits();
        apb(1'b1, 8'h00, 32'h00400000);
        apb(1'b0, 8'h00, 32'h00000000);
        `CHK(rdat, 32'h00320000)
        apb(1'b1, 8'h00, 32'hff000000);
        apb(1'b0, 8'h00, 32'h00000000);
        `CHK(rdat, 32'hffce0000)
        ctrl(0, 3'h4, 1'b1);
        obs(0);
        `CHK(pin, 24'sh320000)
        ctrl(0, 3'h5, 1'b1);
        obs(0);
        `CHK(pin, 24'sh320000)
    endtask

    // unmapped place and a write to the read-only output both refused
    task automatic t_bad();
        apb(1'b0, 8'h20, 32'h00000000);
        `CHK({rerr, rdat}, 33'h100000000)
        apb(1'b1, 8'h1c, 32'h00000055);
        `CHK(rerr, 1'b1)
        obs(1);
        `CHK(rv, 32'h00320000)
    endtask

    // main sequence
    initial
    begin
        i_rst_n = 1'b0;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = 8'h00;
        i_pwdata = 32'h00000000;
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        t_reset_vals();
        t_modes();
        t_toggle();
        t_indep();
        t_limits();
        setup(1, 24'sh320000, 24'sh000000, 3'h0, 1'b0);
        t_bad();
        // second reset in mid-run must clear everything again
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        t_reset_vals();
        summarize();
    end
endmodule
